// [rtl/hti_cfg.svh]
// Overview of operation
// - temperature only: two bytes then CRC
// - combined: humidity, temperature, then CRC
// - hold form stretches SCL until result ready
// - controller keeps SCL at least 200 kHz
// - no-hold form leaves SCL free
// - no-hold read: ACK if ready, else NACK
// - hold: write command, repeated start, read
// - after release, shift bytes on controller clocks
// - address with write wakes, command follows
// - results sent most significant bit first
// - results always presented as 14 bits
// - temperature conversion time per resolution
// - combined conversion time per resolution
// - CRC8 poly 0x1d, init ff, no reflection
// - CRC input humidity bytes then temperature
// - temperature only: zero humidity in CRC
// - periodic read fetches latest stored result
// - periodic mode ignores other commands
// - command 0x30 stops periodic mode
// - after stop, sleep and accept the four measurement commands and 0x30
// - fixed command byte codes
// - target address 0x54, up to 400 kHz
// - resolution bits 1:0 temperature, 3:2 humidity
`ifndef HTI_CFG_SVH
`define HTI_CFG_SVH
`define HTI_ADDR         7'h54
`define HTI_CMD_HOLD_T   8'he3
`define HTI_CMD_NOHOLD_T 8'hf3
`define HTI_CMD_HOLD_HT  8'he5
`define HTI_CMD_NOHOLD_HT 8'hf5
`define HTI_CMD_RD_REG   8'ha7
`define HTI_CMD_WR_REG   8'ha6
`define HTI_CMD_STOP_PER 8'h30
`define HTI_CMD_RD_ID    8'hd7
`define HTI_CRC_POLY     8'h1d
`define HTI_CRC_INIT     8'hff
`define HTI_CRC_XOROUT   8'h00
`define HTI_RES_T_LSB    0
`define HTI_RES_H_LSB    2
`define HTI_MASK_8       14'h3fc0
`define HTI_MASK_10      14'h3ff0
`define HTI_MASK_12      14'h3ffc
`define HTI_MASK_14      14'h3fff
`define HTI_CLK_KHZ      250000
`define HTI_T_T8_MS      0.37
`define HTI_T_T10_MS     0.45
`define HTI_T_T12_MS     0.60
`define HTI_T_T14_MS     0.91
`define HTI_T_HT8_MS     0.64
`define HTI_T_HT10_MS    0.80
`define HTI_T_HT12_MS    1.04
`define HTI_T_HT14_MS    1.70
`define HTI_PER_MS       1000.0
`define HTI_SCL_KHZ      400
`define HTI_SCL_MIN_KHZ  200
`define HTI_SCL_QTR_CYC  ((`HTI_CLK_KHZ + 4 * `HTI_SCL_KHZ - 1) / (4 * `HTI_SCL_KHZ))
`endif

// [rtl/hti_pkg.sv]
package hti_pkg;
	typedef enum logic [2:0] {D_IDLE, D_ADDR, D_CMD, D_ACK, D_TXLD, D_TX, D_MACK} hti_dstate_type;
	typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} hti_hstate_type;
	typedef enum logic [1:0] {S_AW, S_CMD, S_AR, S_DATA} hti_step_type;
endpackage

// [rtl/hti_i2c_if.sv]
`timescale 1ns/1ns
interface hti_i2c_if;
	logic scl_dev_o;
	logic scl_dev_oe;
	logic sda_dev_o;
	logic sda_dev_oe;
	logic scl_host_o;
	logic scl_host_oe;
	logic sda_host_o;
	logic sda_host_oe;
	logic scl;
	logic sda;
	// wired-and with pull-ups
	assign scl = ~((scl_dev_oe & ~scl_dev_o) | (scl_host_oe & ~scl_host_o));
	assign sda = ~((sda_dev_oe & ~sda_dev_o) | (sda_host_oe & ~sda_host_o));
	modport dev (input scl, input sda, output scl_dev_o, output scl_dev_oe, output sda_dev_o, output sda_dev_oe);
	modport host (input scl, input sda, output scl_host_o, output scl_host_oe, output sda_host_o, output sda_host_oe);
endinterface

// [rtl/hti_dev.sv]
`timescale 1ns/1ns
`include "hti_cfg.svh"
module hti_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input  wire logic             ref_clk,
	input  wire logic             rst,
	input  wire logic             flush,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wr_r;
	logic [AW:0]      rd_r;
	assign out_valid = wr_r != rd_r;
	assign in_ready  = (wr_r[AW] == rd_r[AW]) || (wr_r[AW-1:0] != rd_r[AW-1:0]);
	assign out_data  = mem[rd_r[AW-1:0]];
	always_ff @(posedge ref_clk) begin
		if (in_valid && in_ready) begin
			mem[wr_r[AW-1:0]] <= in_data;
		end
	end
	always_ff @(posedge ref_clk) begin
		if (rst || flush) begin
			wr_r <= '0;
			rd_r <= '0;
		end else begin
			if (in_valid && in_ready) begin
				wr_r <= wr_r + 1'b1;
			end
			if (out_valid && out_ready) begin
				rd_r <= rd_r + 1'b1;
			end
		end
	end
endmodule

module hti_dev #(
	parameter int CONV_T8_CYC   = int'(`HTI_T_T8_MS * `HTI_CLK_KHZ),
	parameter int CONV_T10_CYC  = int'(`HTI_T_T10_MS * `HTI_CLK_KHZ),
	parameter int CONV_T12_CYC  = int'(`HTI_T_T12_MS * `HTI_CLK_KHZ),
	parameter int CONV_T14_CYC  = int'(`HTI_T_T14_MS * `HTI_CLK_KHZ),
	parameter int CONV_HT8_CYC  = int'(`HTI_T_HT8_MS * `HTI_CLK_KHZ),
	parameter int CONV_HT10_CYC = int'(`HTI_T_HT10_MS * `HTI_CLK_KHZ),
	parameter int CONV_HT12_CYC = int'(`HTI_T_HT12_MS * `HTI_CLK_KHZ),
	parameter int CONV_HT14_CYC = int'(`HTI_T_HT14_MS * `HTI_CLK_KHZ),
	parameter int PER_CYC       = int'(`HTI_PER_MS * `HTI_CLK_KHZ)
) (
	input  wire logic        ref_clk,
	input  wire logic        rst,
	hti_i2c_if.dev           bus,
	input  wire logic [3:0]  res_cfg,
	input  wire logic [13:0] hum_sample,
	input  wire logic [13:0] temp_sample,
	input  wire logic        periodic_start,
	output logic             conv_busy,
	output logic             periodic_on,
	output logic             result_ready
);
	hti_pkg::hti_dstate_type st_r;
	hti_pkg::hti_dstate_type ack_nxt_r;
	logic        scl_m_r, scl_s_r, scl_d_r;
	logic        sda_m_r, sda_s_r, sda_d_r;
	logic [7:0]  sh_r;
	logic [3:0]  bit_r;
	logic        mack_r;
	logic        sda_oe_r;
	logic        scl_oe_r;
	logic        hold_r;
	logic        cmd_go_r;
	logic        cmd_comb_r;
	logic        stop_cmd_r;
	logic        load_go_r;
	logic        load_pend_r;
	logic [2:0]  load_idx_r;
	logic        per_r;
	logic [31:0] per_cnt_r;
	logic        busy_r;
	logic        comb_r;
	logic [31:0] conv_cnt_r;
	logic        ready_r;
	logic        res_comb_r;
	logic [13:0] res_h_r;
	logic [13:0] res_t_r;
	logic [7:0]  res_crc_r;
	logic        f_in_ready, f_out_valid, f_pop, f_push;
	logic [7:0]  f_out_data;
	logic [13:0] meas_h, meas_t;
	logic [1:0]  res_t, res_h, res_ht;
	logic        per_go;

	function automatic logic [13:0] res_mask(input logic [13:0] v, input logic [1:0] code);
		case (code)
			2'b00:   res_mask = v & `HTI_MASK_8;
			2'b01:   res_mask = v & `HTI_MASK_10;
			2'b10:   res_mask = v & `HTI_MASK_12;
			default: res_mask = v & `HTI_MASK_14;
		endcase
	endfunction

	function automatic logic [7:0] crc8(input logic [31:0] d);
		logic [7:0] c;
		c = `HTI_CRC_INIT;
		for (int i = 31; i >= 0; i--) begin
			if (c[7] ^ d[i]) begin
				c = {c[6:0], 1'b0} ^ `HTI_CRC_POLY;
			end else begin
				c = {c[6:0], 1'b0};
			end
		end
		crc8 = c ^ `HTI_CRC_XOROUT;
	endfunction

	function automatic logic [31:0] conv_cyc(input logic comb, input logic [1:0] code);
		case ({comb, code})
			3'h0:    conv_cyc = CONV_T8_CYC;
			3'h1:    conv_cyc = CONV_T10_CYC;
			3'h2:    conv_cyc = CONV_T12_CYC;
			3'h3:    conv_cyc = CONV_T14_CYC;
			3'h4:    conv_cyc = CONV_HT8_CYC;
			3'h5:    conv_cyc = CONV_HT10_CYC;
			3'h6:    conv_cyc = CONV_HT12_CYC;
			default: conv_cyc = CONV_HT14_CYC;
		endcase
	endfunction

	function automatic logic [7:0] tx_byte(input logic comb, input logic [2:0] idx, input logic [13:0] h,
	                                       input logic [13:0] t, input logic [7:0] crc);
		logic [2:0] e;
		e = comb ? idx : idx + 3'h2;
		case (e)
			3'h0:    tx_byte = {2'b00, h[13:8]};
			3'h1:    tx_byte = h[7:0];
			3'h2:    tx_byte = {2'b00, t[13:8]};
			3'h3:    tx_byte = t[7:0];
			default: tx_byte = crc;
		endcase
	endfunction

	assign bus.scl_dev_o  = 1'b0;
	assign bus.sda_dev_o  = 1'b0;
	assign bus.scl_dev_oe = scl_oe_r;
	assign bus.sda_dev_oe = sda_oe_r;
	assign conv_busy      = busy_r;
	assign periodic_on    = per_r;
	assign result_ready   = ready_r;

	// pins cross in through two flops before any edge logic
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			{scl_m_r, scl_s_r, scl_d_r} <= 3'h7;
			{sda_m_r, sda_s_r, sda_d_r} <= 3'h7;
		end else begin
			{scl_m_r, scl_s_r, scl_d_r} <= {bus.scl, scl_m_r, scl_s_r};
			{sda_m_r, sda_s_r, sda_d_r} <= {bus.sda, sda_m_r, sda_s_r};
		end
	end
	wire scl_rise = scl_s_r & ~scl_d_r;
	wire scl_fall = ~scl_s_r & scl_d_r;
	wire start_c  = scl_s_r & scl_d_r & sda_d_r & ~sda_s_r;
	wire stop_c   = scl_s_r & scl_d_r & ~sda_d_r & sda_s_r;

	assign res_t  = res_cfg[`HTI_RES_T_LSB +: 2];
	assign res_h  = res_cfg[`HTI_RES_H_LSB +: 2];
	assign res_ht = (res_h > res_t) ? res_h : res_t;
	assign meas_t = res_mask(temp_sample, res_t);
	assign meas_h = comb_r ? res_mask(hum_sample, res_h) : 14'h0;
	assign per_go = per_r && (per_cnt_r == 32'(PER_CYC - 1));

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			per_r     <= 1'b0;
			per_cnt_r <= '0;
		end else if (stop_cmd_r) begin
			per_r <= 1'b0;
		end else if (periodic_start) begin
			per_r     <= 1'b1;
			per_cnt_r <= '0;
		end else if (per_r) begin
			per_cnt_r <= per_go ? 32'h0 : per_cnt_r + 32'h1;
		end
	end

	// periodic conversions keep the old result readable; commanded ones retract it
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			busy_r     <= 1'b0;
			comb_r     <= 1'b0;
			conv_cnt_r <= '0;
			ready_r    <= 1'b0;
			res_comb_r <= 1'b0;
			res_h_r    <= '0;
			res_t_r    <= '0;
			res_crc_r  <= '0;
		end else if (!busy_r && (cmd_go_r || per_go)) begin
			busy_r     <= 1'b1;
			comb_r     <= cmd_go_r ? cmd_comb_r : 1'b1;
			conv_cnt_r <= conv_cyc(cmd_go_r ? cmd_comb_r : 1'b1, (cmd_go_r && !cmd_comb_r) ? res_t : res_ht) - 32'h1;
			if (cmd_go_r) begin
				ready_r <= 1'b0;
			end
		end else if (busy_r) begin
			if (conv_cnt_r == 32'h0) begin
				busy_r     <= 1'b0;
				ready_r    <= 1'b1;
				res_comb_r <= comb_r;
				res_h_r    <= meas_h;
				res_t_r    <= meas_t;
				res_crc_r  <= crc8({2'b00, meas_h, 2'b00, meas_t});
			end else begin
				conv_cnt_r <= conv_cnt_r - 32'h1;
			end
		end
	end

	assign f_push = load_pend_r && ready_r;
	always_ff @(posedge ref_clk) begin
		if (rst || start_c || stop_c) begin
			load_pend_r <= 1'b0;
			load_idx_r  <= '0;
		end else if (load_go_r) begin
			load_pend_r <= 1'b1;
			load_idx_r  <= '0;
		end else if (f_push && f_in_ready) begin
			load_idx_r <= load_idx_r + 3'h1;
			if (load_idx_r == (res_comb_r ? 3'h4 : 3'h2)) begin
				load_pend_r <= 1'b0;
			end
		end
	end

	assign f_pop = (st_r == hti_pkg::D_TXLD) && f_out_valid && !start_c && !stop_c;
	hti_fifo #(.WIDTH(8), .DEPTH(16)) u_fifo (
		.ref_clk   (ref_clk),
		.rst       (rst),
		.flush     (start_c || stop_c),
		.in_valid  (f_push),
		.in_ready  (f_in_ready),
		.in_data   (tx_byte(res_comb_r, load_idx_r, res_h_r, res_t_r, res_crc_r)),
		.out_valid (f_out_valid),
		.out_ready (f_pop),
		.out_data  (f_out_data)
	);

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			st_r       <= hti_pkg::D_IDLE;
			ack_nxt_r  <= hti_pkg::D_IDLE;
			sh_r       <= '0;
			bit_r      <= '0;
			mack_r     <= 1'b0;
			sda_oe_r   <= 1'b0;
			scl_oe_r   <= 1'b0;
			hold_r     <= 1'b0;
			cmd_go_r   <= 1'b0;
			cmd_comb_r <= 1'b0;
			stop_cmd_r <= 1'b0;
			load_go_r  <= 1'b0;
		end else begin
			cmd_go_r   <= 1'b0;
			stop_cmd_r <= 1'b0;
			load_go_r  <= 1'b0;
			if (stop_c) begin
				st_r     <= hti_pkg::D_IDLE;
				sda_oe_r <= 1'b0;
				scl_oe_r <= 1'b0;
			end else if (start_c) begin
				st_r     <= hti_pkg::D_ADDR;
				bit_r    <= '0;
				sda_oe_r <= 1'b0;
				scl_oe_r <= 1'b0;
			end else begin
				case (st_r)
					hti_pkg::D_ADDR, hti_pkg::D_CMD: begin
						if (scl_rise) begin
							sh_r  <= {sh_r[6:0], sda_s_r};
							bit_r <= bit_r + 4'h1;
						end else if (scl_fall && bit_r == 4'h8) begin
							bit_r <= '0;
							st_r  <= hti_pkg::D_ACK;
							if (st_r == hti_pkg::D_ADDR) begin
								if (sh_r[7:1] != `HTI_ADDR) begin
									st_r <= hti_pkg::D_IDLE;
								end else if (!sh_r[0]) begin
									sda_oe_r  <= 1'b1;
									ack_nxt_r <= hti_pkg::D_CMD;
								end else if (ready_r || (hold_r && busy_r)) begin
									sda_oe_r  <= 1'b1;
									ack_nxt_r <= hti_pkg::D_TXLD;
									load_go_r <= 1'b1;
								end else begin
									st_r <= hti_pkg::D_IDLE;
								end
							end else if (per_r) begin
								if (sh_r == `HTI_CMD_STOP_PER) begin
									sda_oe_r   <= 1'b1;
									stop_cmd_r <= 1'b1;
									ack_nxt_r  <= hti_pkg::D_IDLE;
								end else begin
									st_r <= hti_pkg::D_IDLE;
								end
							end else if (sh_r == `HTI_CMD_HOLD_T || sh_r == `HTI_CMD_NOHOLD_T ||
							             sh_r == `HTI_CMD_HOLD_HT || sh_r == `HTI_CMD_NOHOLD_HT) begin
								sda_oe_r   <= 1'b1;
								ack_nxt_r  <= hti_pkg::D_IDLE;
								cmd_go_r   <= 1'b1;
								cmd_comb_r <= (sh_r == `HTI_CMD_HOLD_HT) || (sh_r == `HTI_CMD_NOHOLD_HT);
								hold_r     <= (sh_r == `HTI_CMD_HOLD_T) || (sh_r == `HTI_CMD_HOLD_HT);
							end else if (sh_r == `HTI_CMD_STOP_PER) begin
								sda_oe_r  <= 1'b1;
								ack_nxt_r <= hti_pkg::D_IDLE;
							end else begin
								st_r <= hti_pkg::D_IDLE;
							end
						end
					end
					hti_pkg::D_ACK: begin
						if (scl_fall) begin
							sda_oe_r <= 1'b0;
							st_r     <= ack_nxt_r;
						end
					end
					hti_pkg::D_TXLD: begin
						if (f_out_valid) begin
							sh_r     <= f_out_data;
							sda_oe_r <= ~f_out_data[7];
							bit_r    <= '0;
							st_r     <= hti_pkg::D_TX;
						end else if (load_pend_r) begin
							scl_oe_r <= 1'b1;
						end else begin
							scl_oe_r <= 1'b0;
							st_r     <= hti_pkg::D_IDLE;
						end
					end
					hti_pkg::D_TX: begin
						// data set up last cycle; free the stretched clock only now
						if (scl_oe_r) begin
							scl_oe_r <= 1'b0;
						end
						if (scl_fall) begin
							if (bit_r == 4'h7) begin
								sda_oe_r <= 1'b0;
								st_r     <= hti_pkg::D_MACK;
							end else begin
								sda_oe_r <= ~sh_r[6];
								sh_r     <= {sh_r[6:0], 1'b0};
								bit_r    <= bit_r + 4'h1;
							end
						end
					end
					hti_pkg::D_MACK: begin
						if (scl_rise) begin
							mack_r <= ~sda_s_r;
						end else if (scl_fall) begin
							st_r <= mack_r ? hti_pkg::D_TXLD : hti_pkg::D_IDLE;
						end
					end
					hti_pkg::D_IDLE: begin
						sda_oe_r <= 1'b0;
					end
					default: begin
						st_r <= hti_pkg::D_IDLE;
					end
				endcase
			end
		end
	end
endmodule

// [rtl/hti_host.sv]
`timescale 1ns/1ns
`include "hti_cfg.svh"
module hti_host (
	input  wire logic       ref_clk,
	input  wire logic       rst,
	hti_i2c_if.host         bus,
	input  wire logic       req_valid,
	input  wire logic       req_cmd_en,
	input  wire logic [7:0] req_cmd,
	input  wire logic [2:0] req_rd_len,
	output logic            req_ready,
	output logic [7:0]      rx_data,
	output logic            rx_valid,
	output logic            nack_err,
	output logic            done
);
	hti_pkg::hti_hstate_type hs_r;
	hti_pkg::hti_step_type   step_r;
	logic       scl_m_r, scl_s_r, sda_m_r, sda_s_r;
	logic [1:0] ph_r;
	logic [7:0] div_r;
	logic [3:0] bitn_r;
	logic [8:0] tx_r;
	logic [8:0] rx_r;
	logic [2:0] left_r;
	logic [7:0] cmd_r;
	logic       rd_r;
	logic       retry_r;
	logic       scl_oe_r, sda_oe_r;
	logic       ready_r, rx_valid_r, nack_r, done_r;
	logic [7:0] rx_data_r;

	function automatic logic [8:0] tx_load(input hti_pkg::hti_step_type s, input logic [7:0] c, input logic [2:0] n);
		case (s)
			hti_pkg::S_AW:  tx_load = {`HTI_ADDR, 1'b0, 1'b1};
			hti_pkg::S_CMD: tx_load = {c, 1'b1};
			hti_pkg::S_AR:  tx_load = {`HTI_ADDR, 1'b1, 1'b1};
			default:        tx_load = {8'hff, n == 3'h1};
		endcase
	endfunction

	assign bus.scl_host_o  = 1'b0;
	assign bus.sda_host_o  = 1'b0;
	assign bus.scl_host_oe = scl_oe_r;
	assign bus.sda_host_oe = sda_oe_r;
	assign req_ready       = ready_r;
	assign rx_data         = rx_data_r;
	assign rx_valid        = rx_valid_r;
	assign nack_err        = nack_r;
	assign done            = done_r;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			{scl_m_r, scl_s_r} <= 2'h3;
			{sda_m_r, sda_s_r} <= 2'h3;
		end else begin
			{scl_m_r, scl_s_r} <= {bus.scl, scl_m_r};
			{sda_m_r, sda_s_r} <= {bus.sda, sda_m_r};
		end
	end

	// quarter-bit divider; it waits in the high phase so a stretching target is honoured
	wire stall = (ph_r == 2'd2) && !scl_s_r;
	wire tick  = (div_r == 8'(`HTI_SCL_QTR_CYC - 1)) && !stall;
	always_ff @(posedge ref_clk) begin
		if (rst || hs_r == hti_pkg::H_IDLE) begin
			div_r <= '0;
		end else if (div_r != 8'(`HTI_SCL_QTR_CYC - 1)) begin
			div_r <= div_r + 8'h1;
		end else if (!stall) begin
			div_r <= '0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			hs_r       <= hti_pkg::H_IDLE;
			step_r     <= hti_pkg::S_AW;
			ph_r       <= '0;
			bitn_r     <= '0;
			tx_r       <= '1;
			rx_r       <= '0;
			left_r     <= '0;
			cmd_r      <= '0;
			rd_r       <= 1'b0;
			retry_r    <= 1'b0;
			scl_oe_r   <= 1'b0;
			sda_oe_r   <= 1'b0;
			ready_r    <= 1'b1;
			rx_valid_r <= 1'b0;
			nack_r     <= 1'b0;
			done_r     <= 1'b0;
			rx_data_r  <= '0;
		end else begin
			rx_valid_r <= 1'b0;
			done_r     <= 1'b0;
			case (hs_r)
				hti_pkg::H_IDLE: begin
					if (req_valid && (req_cmd_en || req_rd_len != 3'h0)) begin
						ready_r <= 1'b0;
						nack_r  <= 1'b0;
						cmd_r   <= req_cmd;
						left_r  <= req_rd_len;
						rd_r    <= req_rd_len != 3'h0;
						step_r  <= req_cmd_en ? hti_pkg::S_AW : hti_pkg::S_AR;
						ph_r    <= '0;
						hs_r    <= hti_pkg::H_START;
					end
				end
				hti_pkg::H_START: begin
					if (tick) begin
						ph_r <= ph_r + 2'd1;
						case (ph_r)
							2'd0: sda_oe_r <= 1'b0;
							2'd1: scl_oe_r <= 1'b0;
							2'd2: sda_oe_r <= 1'b1;
							default: begin
								scl_oe_r <= 1'b1;
								bitn_r   <= '0;
								tx_r     <= tx_load(step_r, cmd_r, left_r);
								hs_r     <= hti_pkg::H_BIT;
							end
						endcase
					end
				end
				hti_pkg::H_BIT: begin
					if (tick) begin
						ph_r <= ph_r + 2'd1;
						case (ph_r)
							2'd0: begin
								sda_oe_r <= ~tx_r[8];
								tx_r     <= {tx_r[7:0], 1'b1};
							end
							2'd1: scl_oe_r <= 1'b0;
							2'd2: rx_r <= {rx_r[7:0], sda_s_r};
							default: begin
								scl_oe_r <= 1'b1;
								bitn_r   <= bitn_r + 4'h1;
								if (bitn_r == 4'h8) begin
									bitn_r <= '0;
									case (step_r)
										hti_pkg::S_AW: begin
											if (rx_r[0]) begin
												nack_r <= 1'b1;
												hs_r   <= hti_pkg::H_STOP;
											end else begin
												step_r <= hti_pkg::S_CMD;
												tx_r   <= tx_load(hti_pkg::S_CMD, cmd_r, left_r);
											end
										end
										hti_pkg::S_CMD: begin
											if (rx_r[0]) begin
												nack_r <= 1'b1;
												hs_r   <= hti_pkg::H_STOP;
											end else if (rd_r) begin
												step_r <= hti_pkg::S_AR;
												hs_r   <= hti_pkg::H_START;
											end else begin
												hs_r <= hti_pkg::H_STOP;
											end
										end
										hti_pkg::S_AR: begin
											if (rx_r[0]) begin
												retry_r <= 1'b1;
												hs_r    <= hti_pkg::H_STOP;
											end else begin
												step_r <= hti_pkg::S_DATA;
												tx_r   <= tx_load(hti_pkg::S_DATA, cmd_r, left_r);
											end
										end
										default: begin
											rx_data_r  <= rx_r[8:1];
											rx_valid_r <= 1'b1;
											left_r     <= left_r - 3'h1;
											tx_r       <= tx_load(hti_pkg::S_DATA, cmd_r, left_r - 3'h1);
											if (left_r == 3'h1) begin
												hs_r <= hti_pkg::H_STOP;
											end
										end
									endcase
								end
							end
						endcase
					end
				end
				hti_pkg::H_STOP: begin
					if (tick) begin
						ph_r <= ph_r + 2'd1;
						case (ph_r)
							2'd0: sda_oe_r <= 1'b1;
							2'd1: scl_oe_r <= 1'b0;
							2'd2: sda_oe_r <= 1'b1;
							default: begin
								sda_oe_r <= 1'b0;
								if (retry_r) begin
									retry_r <= 1'b0;
									step_r  <= hti_pkg::S_AR;
									hs_r    <= hti_pkg::H_START;
								end else begin
									done_r  <= 1'b1;
									ready_r <= 1'b1;
									hs_r    <= hti_pkg::H_IDLE;
								end
							end
						endcase
					end
				end
				default: hs_r <= hti_pkg::H_IDLE;
			endcase
		end
	end
endmodule

// [verification/hti_i2c_asserts.sv]
`timescale 1ns/1ns
module hti_i2c_asserts #(
	parameter int CONV_T8_CYC = 1, parameter int CONV_T10_CYC = 1,
	parameter int CONV_T12_CYC = 1, parameter int CONV_T14_CYC = 1,
	parameter int CONV_HT8_CYC = 1, parameter int CONV_HT10_CYC = 1,
	parameter int CONV_HT12_CYC = 1, parameter int CONV_HT14_CYC = 1
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic scl,
	input wire logic scl_dev_oe,
	input wire logic sda_dev_oe,
	input wire logic scl_host_oe,
	input wire logic conv_busy,
	input wire logic result_ready
);
	int busy_cnt_r;
	// counts the cycles of the running conversion
	always_ff @(posedge ref_clk) begin
		if (rst || !conv_busy)
			busy_cnt_r <= 0;
		else
			busy_cnt_r <= busy_cnt_r + 1;
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	reset_idle_a: assert property ($fell(rst) |-> !scl_dev_oe && !sda_dev_oe && !scl_host_oe && !conv_busy)
		else $error("bus not free after reset");
	stretch_low_a: assert property ($rose(scl_dev_oe) |-> !scl)
		else $error("stretch began with clock high");
	stretch_done_a: assert property ($fell(scl_dev_oe) |-> !conv_busy && result_ready)
		else $error("clock released before result");
	release_soon_a: assert property ($fell(conv_busy) && scl_dev_oe |-> ##[1:40] !scl_dev_oe)
		else $error("clock held after conversion");
	sda_steady_a: assert property ($changed(sda_dev_oe) |-> !scl)
		else $error("data changed while clock high");
	scl_rate_a: assert property ($fell(scl) |-> ##[1:700] (scl || scl_dev_oe))
		else $error("clock low too long");
	conv_len_a: assert property ($fell(conv_busy) |-> busy_cnt_r inside {CONV_T8_CYC, CONV_T10_CYC,
		CONV_T12_CYC, CONV_T14_CYC, CONV_HT8_CYC, CONV_HT10_CYC, CONV_HT12_CYC, CONV_HT14_CYC})
		else $error("conversion length wrong");
	ready_end_a: assert property ($fell(conv_busy) |-> result_ready)
		else $error("result not ready at conversion end");
endmodule

// [verification/hti_test.sv]
`timescale 1ns/1ns
module hti_test;
	logic ref_clk, rst, req_valid, req_cmd_en, req_ready, rx_valid, nack_err, done, stretched;
	logic conv_busy, periodic_on, result_ready, periodic_start;
	logic [7:0] req_cmd, rx_data;
	logic [7:0] rxq[$], expq[$];
	logic [2:0] req_rd_len;
	logic [3:0] res_cfg;
	logic [13:0] hum_sample, temp_sample;
	logic [31:0] seed;
	int bad_count, check_count;
	hti_i2c_if bus();
	hti_dev #(.CONV_T8_CYC(9000), .CONV_T10_CYC(9100), .CONV_T12_CYC(9200), .CONV_T14_CYC(9300),
		.CONV_HT8_CYC(9400), .CONV_HT10_CYC(9500), .CONV_HT12_CYC(9600), .CONV_HT14_CYC(9700),
		.PER_CYC(60000)) i_hti_dev(.ref_clk(ref_clk), .rst(rst), .bus(bus), .res_cfg(res_cfg),
		.hum_sample(hum_sample), .temp_sample(temp_sample), .periodic_start(periodic_start),
		.conv_busy(conv_busy), .periodic_on(periodic_on), .result_ready(result_ready));
	hti_host i_hti_host(.ref_clk(ref_clk), .rst(rst), .bus(bus), .req_valid(req_valid),
		.req_cmd_en(req_cmd_en), .req_cmd(req_cmd), .req_rd_len(req_rd_len), .req_ready(req_ready),
		.rx_data(rx_data), .rx_valid(rx_valid), .nack_err(nack_err), .done(done));
	hti_i2c_asserts #(.CONV_T8_CYC(9000), .CONV_T10_CYC(9100), .CONV_T12_CYC(9200),
		.CONV_T14_CYC(9300), .CONV_HT8_CYC(9400), .CONV_HT10_CYC(9500), .CONV_HT12_CYC(9600),
		.CONV_HT14_CYC(9700)) i_asserts(.ref_clk(ref_clk), .rst(rst), .scl(bus.scl),
		.scl_dev_oe(bus.scl_dev_oe), .sda_dev_oe(bus.sda_dev_oe), .scl_host_oe(bus.scl_host_oe),
		.conv_busy(conv_busy), .result_ready(result_ready));
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		if (rx_valid === 1'b1)
			rxq.push_back(rx_data);
		if (bus.scl_dev_oe === 1'b1)
			stretched = 1'b1;
	end
	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function logic [13:0] msk(logic [1:0] r, logic [13:0] v);
		return v & (14'h3fff << (6 - 2 * r));
	endfunction
	function logic [7:0] crc8(logic [31:0] d);
		logic [7:0] c;
		c = 8'hff;
		for (int i = 31; i >= 0; i--)
			c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h1d : 8'h00);
		return c;
	endfunction
	task chk(string what, logic [7:0] exp, logic [7:0] got);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task end_of_test();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task req(logic en, logic [7:0] cmd, logic [2:0] len);
		int n;
		req_valid = 1'b1;
		req_cmd_en = en;
		req_cmd = cmd;
		req_rd_len = len;
		@(posedge ref_clk);
		#1 req_valid = 1'b0;
		// bounded by the longest transfer plus a conversion
		for (n = 0; n < 70000 && done !== 1'b1; n++) begin
			@(posedge ref_clk);
			#1;
		end
		if (done !== 1'b1)
			bad_count++;
	endtask
	task run(logic hold, logic comb);
		logic [31:0] r;
		logic [13:0] hh, th;
		logic [7:0] cmd;
		r = rnd();
		res_cfg = r[3:0];
		hum_sample = r[17:4];
		temp_sample = r[31:18];
		th = msk(res_cfg[1:0], temp_sample);
		hh = comb ? msk(res_cfg[3:2], hum_sample) : 14'h0000;
		expq = {};
		if (comb) begin
			expq.push_back({2'b00, hh[13:8]});
			expq.push_back(hh[7:0]);
		end
		expq.push_back({2'b00, th[13:8]});
		expq.push_back(th[7:0]);
		expq.push_back(crc8({2'b00, hh, 2'b00, th}));
		cmd = {hold ? 4'he : 4'hf, comb ? 4'h5 : 4'h3};
		rxq = {};
		stretched = 1'b0;
		if (hold)
			req(1'b1, cmd, comb ? 3'h5 : 3'h3);
		else begin
			req(1'b1, cmd, 3'h0);
			req(1'b0, 8'h00, comb ? 3'h5 : 3'h3);
		end
		chk("byte count", 8'(expq.size()), 8'(rxq.size()));
		foreach (expq[i])
			chk("result byte", expq[i], rxq[i]);
		chk("stretch", {7'h00, hold}, {7'h00, stretched});
		$display("measure test %h ended", cmd);
	endtask
	initial begin
		rst = 1'b1;
		{req_valid, req_cmd_en, req_cmd, req_rd_len, res_cfg, hum_sample, temp_sample} = '0;
		{periodic_start, stretched} = '0;
		seed = 32'd87304;
		bad_count = 0;
		check_count = 0;
		repeat (8) @(posedge ref_clk);
		#1 rst = 1'b0;
		run(1'b1, 1'b1);
		run(1'b0, 1'b0);
		// periodic mode refuses measurements until stopped
		periodic_start = 1'b1;
		@(posedge ref_clk);
		#1 periodic_start = 1'b0;
		@(posedge ref_clk);
		#1;
		chk("periodic on", 8'h01, {7'h00, periodic_on});
		req(1'b1, 8'hf3, 3'h0);
		chk("periodic cmd nack", 8'h01, {7'h00, nack_err});
		req(1'b1, 8'h30, 3'h0);
		chk("stop cmd nack", 8'h00, {7'h00, nack_err});
		chk("periodic off", 8'h00, {7'h00, periodic_on});
		req(1'b1, 8'ha7, 3'h0);
		chk("other cmd nack", 8'h01, {7'h00, nack_err});
		$display("command test ended");
		end_of_test();
	end
	initial begin
		#(4 * 200000);
		bad_count++;
		end_of_test();
	end
endmodule
